// *** cache_model.sv ***
`timescale 1ns/1ns
`include "lsb_consts.svh"

module cache_model import lsb_pkg::*; (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_b,
  // load port
  input wire logic                dc_ld_req_r,
  input wire logic [5:0]          dc_ld_tag_r,
  input wire logic [`LSB_AW-1:0]  dc_ld_addr_r,
  output logic                    dc_ld_miss,
  output logic                    dc_ld_resp_valid,
  output logic [5:0]              dc_ld_resp_tag,
  output logic [`LSB_DW-1:0]      dc_ld_resp_data,
  output logic                    dc_ld_resp_fill,
  // store port
  input wire logic                dc_st_req_r,
  output logic                    dc_st_ack
);
  int          due[$];
  logic [5:0]  qtag[$];
  logic [31:0] qadr[$];
  int          now, sc, k;
  // address bit 12 picks miss; misses go to slow memory
  assign dc_ld_miss = dc_ld_addr_r[12];
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      due.delete();
      qtag.delete();
      qadr.delete();
      now = 0;
      sc = 0;
      dc_ld_resp_valid <= 1'b0;
      dc_ld_resp_tag <= 6'h0;
      dc_ld_resp_data <= 64'h0;
      dc_ld_resp_fill <= 1'b0;
      dc_st_ack <= 1'b0;
    end else begin
      now++;
      if (dc_ld_req_r) begin
        due.push_back(now + (dc_ld_miss ? 12 : 1));
        qtag.push_back(dc_ld_tag_r);
        qadr.push_back(dc_ld_addr_r);
      end
      // idle tag and data lines toggle so a stale value is never mistaken for data
      dc_ld_resp_valid <= 1'b0;
      dc_ld_resp_tag <= ~dc_ld_resp_tag;
      dc_ld_resp_data <= ~dc_ld_resp_data;
      for (k = 0; k < due.size(); k++) begin
        if (due[k] <= now) begin
          dc_ld_resp_valid <= 1'b1;
          dc_ld_resp_tag <= qtag[k];
          dc_ld_resp_data <= {32'h0, qadr[k]};
          dc_ld_resp_fill <= qadr[k][12];
          due.delete(k);
          qtag.delete(k);
          qadr.delete(k);
          break;
        end
      end
      // slow writes, three cycles of wait per store
      if (dc_st_req_r && !dc_st_ack) sc++;
      dc_st_ack <= dc_st_req_r && !dc_st_ack && sc == 3;
      if (dc_st_ack) sc = 0;
    end
  end
endmodule : cache_model

// *** load_store_buffer_unit.sv ***
`timescale 1ns/1ns
`include "lsb_consts.svh"

module load_store_buffer_unit import lsb_pkg::*; (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // allocation at dispatch
  input  wire logic                   ld_alloc_req,
  output logic                        ld_alloc_rdy_r,
  output logic [5:0]                  ld_alloc_tag_r,
  input  wire logic                   st_alloc_req,
  output logic                        st_alloc_rdy_r,
  output logic [4:0]                  st_alloc_tag_r,
  // load issue
  input  wire logic                   ld_issue_valid,
  output logic                        ld_issue_rdy_r,
  input  wire logic [5:0]             ld_issue_tag,
  input  wire logic [`LSB_AW-1:0]     ld_issue_addr,
  input  wire logic [1:0]             ld_issue_size,
  input  wire logic                   ld_issue_spec,
  input  wire logic                   ld_issue_xlat_fault,
  // store issue
  input  wire logic                   st_issue_valid,
  input  wire logic [4:0]             st_issue_tag,
  input  wire logic [`LSB_AW-1:0]     st_issue_addr,
  input  wire logic [1:0]             st_issue_size,
  input  wire logic [`LSB_DW-1:0]     st_issue_data,
  // retirement
  input  wire logic                   ld_retire,
  input  wire logic                   st_retire,
  // forwarded or faulting load result
  output logic                        fwd_valid_r,
  output logic [5:0]                  fwd_tag_r,
  output logic [`LSB_DW-1:0]          fwd_data,
  output logic                        fwd_fault_r,
  output logic                        fwd_replay_r,
  // cache load port
  output logic                        dc_ld_req_r,
  output logic [5:0]                  dc_ld_tag_r,
  output logic [`LSB_AW-1:0]          dc_ld_addr_r,
  output logic [1:0]                  dc_ld_size_r,
  input  wire logic                   dc_ld_miss,
  input  wire logic                   dc_ld_resp_valid,
  input  wire logic [5:0]             dc_ld_resp_tag,
  input  wire logic [`LSB_DW-1:0]     dc_ld_resp_data,
  input  wire logic                   dc_ld_resp_fill,
  // load completion from cache
  output logic                        ld_done_valid_r,
  output logic [5:0]                  ld_done_tag_r,
  output logic [`LSB_DW-1:0]          ld_done_data_r,
  // cache store port
  output logic                        dc_st_req_r,
  output logic [`LSB_AW-1:0]          dc_st_addr_r,
  output logic [1:0]                  dc_st_size_r,
  output logic [`LSB_DW-1:0]          dc_st_data_r,
  input  wire logic                   dc_st_ack
);

  store_data_if sd ();

  store_data_ram u_ram (
    .ref_clk (ref_clk),
    .sd      (sd.mem)
  );

  // ==========
  // state
  logic [`LSB_AW-1:0] st_addr_r [`LSB_ST_N];
  logic [1:0]         st_size_r [`LSB_ST_N];
  logic [5:0]         ld_snap_r [`LSB_LD_N];
  logic [`LSB_ST_N-1:0] st_valid_r, st_valid_nxt, st_exec_r, st_exec_nxt;
  logic [`LSB_LD_N-1:0] ld_done_r, ld_done_nxt;
  logic [5:0]  ld_head_r, ld_head_nxt, ld_tail_r, ld_tail_nxt, ld_cnt_r, ld_cnt_nxt;
  logic [4:0]  st_head_r, st_head_nxt, st_tail_r, st_tail_nxt;
  logic [4:0]  st_cnt_r, st_cnt_nxt, st_ret_r, st_ret_nxt;
  logic        st_hwrap_r, st_hwrap_nxt, st_twrap_r, st_twrap_nxt;
  logic [2:0]  miss_r, miss_nxt;
  logic        park_r, park_nxt;
  logic [5:0]  park_tag_r, park_tag_nxt;
  logic [`LSB_AW-1:0] park_addr_r, park_addr_nxt;
  logic [1:0]  park_size_r, park_size_nxt;
  logic [4:0]  park_st_r, park_st_nxt;
  wb_state_type wb_r, wb_nxt;

  // ==========
  // age search against older stores
  logic [4:0]           age_w [`LSB_ST_N];
  logic [`LSB_ST_N-1:0] hit_w;
  logic [5:0]           snap;
  logic [4:0]           snap_age;
  logic [`LSB_AW:0]     ld_end;

  always_comb begin
    snap     = ld_snap_r[ld_issue_tag];
    snap_age = (snap[4:0] >= st_head_r) ? snap[4:0] - st_head_r
                                        : snap[4:0] + `LSB_ST_N_AGE - st_head_r;
    if (snap[4:0] == st_head_r && snap[5] != st_hwrap_r) begin
      snap_age = `LSB_ST_N_AGE;
    end
    ld_end = {1'b0, ld_issue_addr} + (`LSB_AW+1)'(4'h1 << ld_issue_size);
  end

  for (genvar i = 0; i < `LSB_ST_N; i++) begin : g_st
    logic [`LSB_AW:0] st_end;
    assign age_w[i] = (5'(i) >= st_head_r) ? 5'(i) - st_head_r
                                           : 5'(i) + `LSB_ST_N_AGE - st_head_r;
    assign st_end   = {1'b0, st_addr_r[i]} + (`LSB_AW+1)'(4'h1 << st_size_r[i]);
    // unexecuted stores are predicted to miss the load address
    assign hit_w[i] = st_valid_r[i] && st_exec_r[i] && (age_w[i] < snap_age)
                      && ({1'b0, ld_issue_addr} < st_end)
                      && ({1'b0, st_addr_r[i]} < ld_end);
  end

  logic       any_hit;
  logic [4:0] pick, pick_age;
  logic [6:0] st_line_end;
  logic       fwd_ok;

  always_comb begin
    any_hit  = 1'b0;
    pick     = 5'h0;
    pick_age = 5'h0;
    // youngest older store wins
    for (int k = 0; k < `LSB_ST_N; k++) begin
      if (hit_w[k] && (!any_hit || age_w[k] > pick_age)) begin
        any_hit  = 1'b1;
        pick     = 5'(k);
        pick_age = age_w[k];
      end
    end
    st_line_end = {1'b0, st_addr_r[pick][`LSB_OFS_MSB:0]} + (7'h1 << st_size_r[pick]);
    fwd_ok = (st_addr_r[pick] == ld_issue_addr)
             && (ld_issue_size <= st_size_r[pick])
             && (st_line_end <= `LSB_LINE_BYTES);
  end

  // ==========
  // load path
  logic ld_acc, st_acc, ld_alloc, st_alloc, park_go, wb_free;
  logic fwd_v_nxt, fwd_f_nxt, fwd_rp_nxt, req_nxt;
  logic [5:0] req_tag_nxt;
  logic [`LSB_AW-1:0] req_addr_nxt;
  logic [1:0] req_size_nxt;

  assign ld_acc   = ld_issue_valid && ld_issue_rdy_r;
  assign st_acc   = st_issue_valid;
  assign ld_alloc = ld_alloc_req && ld_alloc_rdy_r;
  assign st_alloc = st_alloc_req && st_alloc_rdy_r;
  assign park_go  = park_r && !st_valid_r[park_st_r] && (miss_r < `LSB_MISS_MAX);

  always_comb begin
    fwd_v_nxt     = 1'b0;
    fwd_f_nxt     = 1'b0;
    fwd_rp_nxt    = 1'b0;
    req_nxt       = 1'b0;
    req_tag_nxt   = ld_issue_tag;
    req_addr_nxt  = ld_issue_addr;
    req_size_nxt  = ld_issue_size;
    park_nxt      = park_r;
    park_tag_nxt  = park_tag_r;
    park_addr_nxt = park_addr_r;
    park_size_nxt = park_size_r;
    park_st_nxt   = park_st_r;
    if (park_go) begin
      req_nxt      = 1'b1;
      req_tag_nxt  = park_tag_r;
      req_addr_nxt = park_addr_r;
      req_size_nxt = park_size_r;
      park_nxt     = 1'b0;
    end else if (ld_acc) begin
      if (ld_issue_xlat_fault) begin
        fwd_v_nxt  = 1'b1;
        fwd_f_nxt  = !ld_issue_spec;
        fwd_rp_nxt = ld_issue_spec;
      end else if (any_hit && fwd_ok) begin
        fwd_v_nxt = 1'b1;
      end else if (any_hit) begin
        park_nxt      = 1'b1;
        park_tag_nxt  = ld_issue_tag;
        park_addr_nxt = ld_issue_addr;
        park_size_nxt = ld_issue_size;
        park_st_nxt   = pick;
      end else begin
        req_nxt = 1'b1;
      end
    end
    // cache verdict arrives with the request, fill ends a miss
    miss_nxt = miss_r + 3'((dc_ld_req_r && dc_ld_miss) ? 1 : 0)
                      - 3'((dc_ld_resp_valid && dc_ld_resp_fill) ? 1 : 0);
  end

  // ==========
  // buffer bookkeeping
  always_comb begin
    ld_head_nxt  = ld_head_r;
    ld_tail_nxt  = ld_tail_r;
    ld_cnt_nxt   = ld_cnt_r;
    ld_done_nxt  = ld_done_r;
    st_head_nxt  = st_head_r;
    st_hwrap_nxt = st_hwrap_r;
    st_tail_nxt  = st_tail_r;
    st_twrap_nxt = st_twrap_r;
    st_cnt_nxt   = st_cnt_r;
    st_ret_nxt   = st_ret_r;
    st_valid_nxt = st_valid_r;
    st_exec_nxt  = st_exec_r;
    if (ld_retire && ld_cnt_r != 6'h0 && ld_done_r[ld_head_r]) begin
      ld_done_nxt[ld_head_r] = 1'b0;
      ld_head_nxt = (ld_head_r == `LSB_LD_LAST) ? 6'h0 : ld_head_r + 6'h1;
      ld_cnt_nxt  = ld_cnt_nxt - 6'h1;
    end
    if (ld_alloc) begin
      ld_tail_nxt = (ld_tail_r == `LSB_LD_LAST) ? 6'h0 : ld_tail_r + 6'h1;
      ld_cnt_nxt  = ld_cnt_nxt + 6'h1;
    end
    // a completion beats a same-cycle clear
    if (fwd_v_nxt) begin
      ld_done_nxt[ld_issue_tag] = 1'b1;
    end
    if (dc_ld_resp_valid) begin
      ld_done_nxt[dc_ld_resp_tag] = 1'b1;
    end
    if (st_retire) begin
      st_ret_nxt = st_ret_nxt + 5'h1;
    end
    if (wb_free) begin
      st_valid_nxt[st_head_r] = 1'b0;
      st_exec_nxt[st_head_r]  = 1'b0;
      st_head_nxt  = (st_head_r == `LSB_ST_LAST) ? 5'h0 : st_head_r + 5'h1;
      st_hwrap_nxt = (st_head_r == `LSB_ST_LAST) ? !st_hwrap_r : st_hwrap_r;
      st_cnt_nxt   = st_cnt_nxt - 5'h1;
      st_ret_nxt   = st_ret_nxt - 5'h1;
    end
    if (st_alloc) begin
      st_valid_nxt[st_tail_r] = 1'b1;
      st_tail_nxt  = (st_tail_r == `LSB_ST_LAST) ? 5'h0 : st_tail_r + 5'h1;
      st_twrap_nxt = (st_tail_r == `LSB_ST_LAST) ? !st_twrap_r : st_twrap_r;
      st_cnt_nxt   = st_cnt_nxt + 5'h1;
    end
    if (st_acc) begin
      st_exec_nxt[st_issue_tag] = 1'b1;
    end
  end

  // ==========
  // in-order store writeback
  always_comb begin
    wb_nxt  = wb_r;
    wb_free = 1'b0;
    unique case (wb_r)
      WB_IDLE: begin
        if (st_ret_r != 5'h0 && st_exec_r[st_head_r]) begin
          wb_nxt = WB_READ;
        end
      end
      WB_READ: begin
        wb_nxt = WB_SEND;
      end
      WB_SEND: begin
        if (dc_st_ack) begin
          wb_nxt  = WB_IDLE;
          wb_free = 1'b1;
        end
      end
      default: begin
        wb_nxt = WB_IDLE;
      end
    endcase
  end

  assign sd.we      = st_acc;
  assign sd.waddr   = st_issue_tag;
  assign sd.wdata   = st_issue_data;
  assign sd.raddr_a = pick;
  assign sd.raddr_b = st_head_r;
  assign fwd_data   = sd.rdata_a;

  // ==========
  // registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_head_r <= 6'h0;  ld_tail_r <= 6'h0;  ld_cnt_r <= 6'h0;  ld_done_r <= '0;
      st_head_r <= 5'h0;  st_tail_r <= 5'h0;  st_cnt_r <= 5'h0;  st_ret_r  <= 5'h0;
      st_hwrap_r <= 1'b0; st_twrap_r <= 1'b0; st_valid_r <= '0;  st_exec_r <= '0;
      miss_r <= 3'h0;     park_r <= 1'b0;     park_tag_r <= 6'h0; park_addr_r <= '0;
      park_size_r <= 2'h0; park_st_r <= 5'h0; wb_r <= WB_IDLE;
      ld_alloc_rdy_r <= 1'b1; ld_alloc_tag_r <= 6'h0;
      st_alloc_rdy_r <= 1'b1; st_alloc_tag_r <= 5'h0; ld_issue_rdy_r <= 1'b1;
      fwd_valid_r <= 1'b0; fwd_tag_r <= 6'h0; fwd_fault_r <= 1'b0; fwd_replay_r <= 1'b0;
      dc_ld_req_r <= 1'b0; dc_ld_tag_r <= 6'h0; dc_ld_addr_r <= '0; dc_ld_size_r <= 2'h0;
      ld_done_valid_r <= 1'b0; ld_done_tag_r <= 6'h0; ld_done_data_r <= '0;
      dc_st_req_r <= 1'b0; dc_st_addr_r <= '0; dc_st_size_r <= 2'h0; dc_st_data_r <= '0;
      for (int k = 0; k < `LSB_ST_N; k++) begin
        st_addr_r[k] <= '0;
        st_size_r[k] <= 2'h0;
      end
      for (int k = 0; k < `LSB_LD_N; k++) begin
        ld_snap_r[k] <= 6'h0;
      end
    end else begin
      ld_head_r <= ld_head_nxt;  ld_tail_r <= ld_tail_nxt;  ld_cnt_r <= ld_cnt_nxt;
      ld_done_r <= ld_done_nxt;  st_head_r <= st_head_nxt;  st_tail_r <= st_tail_nxt;
      st_cnt_r <= st_cnt_nxt;    st_ret_r <= st_ret_nxt;    st_hwrap_r <= st_hwrap_nxt;
      st_twrap_r <= st_twrap_nxt; st_valid_r <= st_valid_nxt; st_exec_r <= st_exec_nxt;
      miss_r <= miss_nxt;        park_r <= park_nxt;        park_tag_r <= park_tag_nxt;
      park_addr_r <= park_addr_nxt; park_size_r <= park_size_nxt; park_st_r <= park_st_nxt;
      wb_r <= wb_nxt;
      ld_alloc_rdy_r <= (ld_cnt_nxt < 6'(`LSB_LD_N));
      ld_alloc_tag_r <= ld_tail_nxt;
      st_alloc_rdy_r <= (st_cnt_nxt < 5'(`LSB_ST_N));
      st_alloc_tag_r <= st_tail_nxt;
      // room left for the miss that a new request may add
      ld_issue_rdy_r <= !park_nxt && (miss_nxt + 3'(req_nxt) < `LSB_MISS_MAX);
      fwd_valid_r  <= fwd_v_nxt;
      fwd_tag_r    <= ld_issue_tag;
      fwd_fault_r  <= fwd_f_nxt;
      fwd_replay_r <= fwd_rp_nxt;
      dc_ld_req_r  <= req_nxt;
      dc_ld_tag_r  <= req_tag_nxt;
      dc_ld_addr_r <= req_addr_nxt;
      dc_ld_size_r <= req_size_nxt;
      ld_done_valid_r <= dc_ld_resp_valid;
      ld_done_tag_r   <= dc_ld_resp_tag;
      ld_done_data_r  <= dc_ld_resp_data;
      if (ld_alloc) begin
        ld_snap_r[ld_tail_r] <= {st_twrap_r, st_tail_r};
      end
      if (st_acc) begin
        st_addr_r[st_issue_tag] <= st_issue_addr;
        st_size_r[st_issue_tag] <= st_issue_size;
      end
      if (wb_r == WB_READ) begin
        dc_st_req_r  <= 1'b1;
        dc_st_addr_r <= st_addr_r[st_head_r];
        dc_st_size_r <= st_size_r[st_head_r];
        dc_st_data_r <= sd.rdata_b;
      end else if (wb_free) begin
        dc_st_req_r <= 1'b0;
      end
    end
  end

endmodule : load_store_buffer_unit

// *** lsb_consts.svh ***
// Behaviour
// - one load and one store accepted per cycle
// - dispatch allocates only when matching entry free
// - 48 load entries, 24 store entries
// - entry freed after completion, retirement, deallocation
// - speculative loads never raise a page fault
// - load misses never block later loads; load issue stops while four misses are outstanding
// - loads bypass loads and unrelated stores freely; here load issue stops while a load is parked on a store
// - stores reach memory strictly in program order
// - up to four outstanding load misses tracked
// - buffered stores do not stall later work
// - predicted-same-address load waits for store data; here a load that cannot forward waits until the store is written
// - forward only from older executed store
// - load bytes must lie within store bytes
// - same start address, store within one line
// - forwarded data returned before store retires
`ifndef LSB_CONSTS_SVH
`define LSB_CONSTS_SVH

// ==========
// sizes
`define LSB_LD_N      48
`define LSB_ST_N      24
`define LSB_LD_LAST   6'h2f
`define LSB_ST_LAST   5'h17
`define LSB_ST_N_AGE  5'h18
`define LSB_AW        32
`define LSB_DW        64
`define LSB_MISS_MAX  3'h4

// ==========
// address geometry
`define LSB_LINE_BYTES 7'h40
`define LSB_OFS_MSB    5

`endif

// *** lsb_monitor.sv ***
`timescale 1ns/1ns
`include "lsb_consts.svh"

module lsb_monitor import lsb_pkg::*; (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_b,
  // allocation and issue
  input wire logic                ld_alloc_req,
  input wire logic                ld_alloc_rdy_r,
  input wire logic [5:0]          ld_alloc_tag_r,
  input wire logic                st_alloc_req,
  input wire logic                st_alloc_rdy_r,
  input wire logic [4:0]          st_alloc_tag_r,
  input wire logic                ld_issue_valid,
  input wire logic                ld_issue_rdy_r,
  input wire logic                ld_issue_spec,
  input wire logic                ld_issue_xlat_fault,
  input wire logic                ld_retire,
  // results
  input wire logic                fwd_valid_r,
  input wire logic                fwd_fault_r,
  input wire logic                fwd_replay_r,
  input wire logic                ld_done_valid_r,
  input wire logic [5:0]          ld_done_tag_r,
  input wire logic [`LSB_DW-1:0]  ld_done_data_r,
  // cache side
  input wire logic                dc_ld_req_r,
  input wire logic                dc_ld_miss,
  input wire logic                dc_ld_resp_valid,
  input wire logic [5:0]          dc_ld_resp_tag,
  input wire logic [`LSB_DW-1:0]  dc_ld_resp_data,
  input wire logic                dc_ld_resp_fill,
  input wire logic                dc_st_req_r,
  input wire logic [`LSB_AW-1:0]  dc_st_addr_r,
  input wire logic [`LSB_DW-1:0]  dc_st_data_r,
  input wire logic                dc_st_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ==========
  // outstanding misses, counted from the cache side
  logic [3:0] miss_r, miss_nxt;
  always_comb begin
    miss_nxt = miss_r + {3'h0, dc_ld_req_r && dc_ld_miss}
             - {3'h0, dc_ld_resp_valid && dc_ld_resp_fill};
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) miss_r <= 4'h0;
    else miss_r <= miss_nxt;
  end

  // ==========
  // checks
  AST_LD_TAG_STEP: assert property (ld_alloc_req && ld_alloc_rdy_r |=> ld_alloc_tag_r ==
    (($past(ld_alloc_tag_r) == `LSB_LD_LAST) ? 6'h0 : $past(ld_alloc_tag_r) + 6'h1))
    else $error("load tag did not advance");
  AST_ST_TAG_STEP: assert property (st_alloc_req && st_alloc_rdy_r |=> st_alloc_tag_r ==
    (($past(st_alloc_tag_r) == `LSB_ST_LAST) ? 5'h0 : $past(st_alloc_tag_r) + 5'h1))
    else $error("store tag did not advance");
  AST_LD_FREE: assert property ($rose(ld_alloc_rdy_r) |-> $past(ld_retire))
    else $error("load entry freed without retire");
  AST_ST_FREE: assert property ($rose(st_alloc_rdy_r) |-> $past(dc_st_ack))
    else $error("store entry freed before write");
  AST_FAULT: assert property (ld_issue_valid && ld_issue_rdy_r && ld_issue_xlat_fault |=>
    fwd_valid_r && fwd_fault_r == !$past(ld_issue_spec) && fwd_replay_r == $past(ld_issue_spec))
    else $error("fault reporting wrong");
  AST_FWD_TIME: assert property (fwd_valid_r |-> $past(ld_issue_valid && ld_issue_rdy_r))
    else $error("forward result without issue");
  AST_ST_HOLD: assert property (dc_st_req_r && !dc_st_ack |=>
    dc_st_req_r && $stable(dc_st_addr_r) && $stable(dc_st_data_r))
    else $error("store write dropped before ack");
  AST_ST_GAP: assert property (dc_st_req_r && dc_st_ack |=> !dc_st_req_r)
    else $error("store write held after ack");
  AST_MISS_MAX: assert property (miss_r <= {1'b0, `LSB_MISS_MAX})
    else $error("too many misses outstanding");
  AST_MISS_STOP: assert property (miss_r == {1'b0, `LSB_MISS_MAX} |-> !ld_issue_rdy_r)
    else $error("issue open at miss limit");
  AST_DONE_COPY: assert property (dc_ld_resp_valid |=> ld_done_valid_r &&
    ld_done_tag_r == $past(dc_ld_resp_tag) && ld_done_data_r == $past(dc_ld_resp_data))
    else $error("cache response not passed on");
endmodule : lsb_monitor

bind load_store_buffer_unit lsb_monitor i_lsb_monitor (.*);

// *** lsb_pkg.sv ***
package lsb_pkg;

  // ==========
  // store writeback sequencer
  typedef enum logic [1:0] {
    WB_IDLE = 2'b00,
    WB_READ = 2'b01,
    WB_SEND = 2'b10
  } wb_state_type;

endpackage : lsb_pkg

// *** store_data_if.sv ***
`timescale 1ns/1ns
`include "lsb_consts.svh"

interface store_data_if;
  logic                       we;
  logic [4:0]                 waddr;
  logic [`LSB_DW-1:0]         wdata;
  logic [4:0]                 raddr_a;
  logic [`LSB_DW-1:0]         rdata_a;
  logic [4:0]                 raddr_b;
  logic [`LSB_DW-1:0]         rdata_b;

  modport owner (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport mem   (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : store_data_if

// *** store_data_ram.sv ***
`timescale 1ns/1ns
`include "lsb_consts.svh"

module store_data_ram (
  // clock
  input wire logic    ref_clk,
  // access ports
  store_data_if.mem   sd
);

  logic [`LSB_DW-1:0] mem_r [`LSB_ST_N];
  logic [`LSB_DW-1:0] rdata_a_r;
  logic [`LSB_DW-1:0] rdata_b_r;

  // ==========
  // storage, no reset: contents only read after a write
  always_ff @(posedge ref_clk) begin
    if (sd.we) begin
      mem_r[sd.waddr] <= sd.wdata;
    end
    rdata_a_r <= mem_r[sd.raddr_a];
    rdata_b_r <= mem_r[sd.raddr_b];
  end

  assign sd.rdata_a = rdata_a_r;
  assign sd.rdata_b = rdata_b_r;

endmodule : store_data_ram

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "lsb_consts.svh"

module tb_top import lsb_pkg::*;;
  logic ref_clk, rst_b, ld_alloc_req, ld_alloc_rdy_r, st_alloc_req, st_alloc_rdy_r;
  logic ld_issue_valid, ld_issue_rdy_r, ld_issue_spec, ld_issue_xlat_fault, st_issue_valid;
  logic ld_retire, st_retire, fwd_valid_r, fwd_fault_r, fwd_replay_r, dc_ld_req_r, dc_ld_miss;
  logic dc_ld_resp_valid, dc_ld_resp_fill, ld_done_valid_r, dc_st_req_r, dc_st_ack;
  logic [5:0] ld_alloc_tag_r, ld_issue_tag, fwd_tag_r, dc_ld_tag_r, dc_ld_resp_tag, ld_done_tag_r;
  logic [4:0] st_alloc_tag_r, st_issue_tag;
  logic [1:0] ld_issue_size, st_issue_size, dc_ld_size_r, dc_st_size_r;
  logic [31:0] ld_issue_addr, st_issue_addr, dc_ld_addr_r, dc_st_addr_r;
  logic [63:0] st_issue_data, fwd_data, dc_ld_resp_data, ld_done_data_r, dc_st_data_r;
  int n_mismatch, checks, i;

  load_store_buffer_unit i_load_store_buffer_unit (.*);
  cache_model i_cache_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========
  // helpers
  task conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task timeout();
    n_mismatch++;
    $display("CHECK FAILED wait limit");
    conclude();
  endtask : timeout
  // 0 cache load, 1 load done, 2 store write, 3 store ack
  task await_hi(input int k);
    logic s;
    for (int n = 0; n < 200; n++) begin
      @(negedge ref_clk);
      s = (k == 0) ? dc_ld_req_r : (k == 1) ? ld_done_valid_r : (k == 2) ? dc_st_req_r : dc_st_ack;
      if (s === 1'b1) return;
    end
    timeout();
  endtask : await_hi
  task reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask : reset
  task alloc(input int nl, input int ns);
    @(posedge ref_clk);
    for (int n = 0; n < 8; n++) begin
      ld_alloc_req <= (n < nl);
      st_alloc_req <= (n < ns);
      @(posedge ref_clk);
    end
  endtask : alloc
  task ld_issue(input logic [5:0] t, input logic [31:0] a, input logic [1:0] sz,
                input logic sp, input logic fl);
    @(posedge ref_clk);
    ld_issue_valid <= 1'b1;
    ld_issue_tag <= t;
    ld_issue_addr <= a;
    ld_issue_size <= sz;
    ld_issue_spec <= sp;
    ld_issue_xlat_fault <= fl;
    for (int n = 0; n <= 200; n++) begin
      @(negedge ref_clk);
      if (ld_issue_rdy_r === 1'b1) break;
      if (n == 200) timeout();
    end
    @(posedge ref_clk);
    ld_issue_valid <= 1'b0;
  endtask : ld_issue
  task st_issue(input logic [4:0] t, input logic [31:0] a, input logic [1:0] sz,
                input logic [63:0] d);
    @(posedge ref_clk);
    st_issue_valid <= 1'b1;
    st_issue_tag <= t;
    st_issue_addr <= a;
    st_issue_size <= sz;
    st_issue_data <= d;
    @(posedge ref_clk);
    st_issue_valid <= 1'b0;
  endtask : st_issue
  task st_ret();
    @(posedge ref_clk);
    st_retire <= 1'b1;
    @(posedge ref_clk);
    st_retire <= 1'b0;
  endtask : st_ret

  // ==========
  // scenarios
  task s_capacity();
    @(posedge ref_clk);
    ld_alloc_req <= 1'b1;
    st_alloc_req <= 1'b1;
    for (i = 0; i <= 48; i++) begin
      @(negedge ref_clk);
      chk("ld_tag", ld_alloc_tag_r, i % 48);
      chk("ld_rdy", ld_alloc_rdy_r, i < 48);
      chk("st_tag", st_alloc_tag_r, (i < 24) ? i : 0);
      chk("st_rdy", st_alloc_rdy_r, i < 24);
    end
    @(posedge ref_clk);
    ld_alloc_req <= 1'b0;
    st_alloc_req <= 1'b0;
    reset();
  endtask : s_capacity
  task s_order();
    alloc(1, 2);
    st_issue(5'h1, 32'h200, 2'h3, 64'h11);
    st_issue(5'h0, 32'h100, 2'h3, 64'h22);
    ld_issue(6'h0, 32'h300, 2'h3, 1'b0, 1'b0);
    await_hi(0);
    chk("ld_addr", dc_ld_addr_r, 32'h300);
    await_hi(1);
    chk("ld_data", ld_done_data_r, 64'h300);
    st_ret();
    st_ret();
    await_hi(2);
    chk("st_first", dc_st_addr_r, 32'h100);
    chk("st_data", dc_st_data_r, 64'h22);
    await_hi(3);
    await_hi(2);
    chk("st_second", dc_st_addr_r, 32'h200);
    reset();
  endtask : s_order
  task s_forward();
    alloc(0, 1);
    alloc(1, 0);
    st_issue(5'h0, 32'h80, 2'h3, 64'h0123456789abcdef);
    ld_issue(6'h0, 32'h80, 2'h2, 1'b0, 1'b0);
    @(negedge ref_clk);
    chk("fwd_valid", fwd_valid_r, 1'b1);
    chk("fwd_tag", fwd_tag_r, 6'h0);
    chk("fwd_data", fwd_data, 64'h0123456789abcdef);
    chk("no_cache", dc_ld_req_r, 1'b0);
    chk("no_write", dc_st_req_r, 1'b0);
    reset();
  endtask : s_forward
  task s_nofwd(input logic [31:0] sa, input logic [1:0] ss, input logic [31:0] la,
               input logic [1:0] ls);
    alloc(0, 1);
    alloc(1, 0);
    st_issue(5'h0, sa, ss, 64'h5a5a);
    ld_issue(6'h0, la, ls, 1'b0, 1'b0);
    repeat (3) begin
      @(negedge ref_clk);
      chk("no_fwd", fwd_valid_r, 1'b0);
      chk("parked", dc_ld_req_r, 1'b0);
      chk("issue_shut", ld_issue_rdy_r, 1'b0);
    end
    st_ret();
    await_hi(3);
    await_hi(0);
    chk("late_addr", dc_ld_addr_r, la);
    reset();
  endtask : s_nofwd
  task s_fault();
    alloc(2, 0);
    ld_issue(6'h0, 32'h40, 2'h2, 1'b1, 1'b1);
    @(negedge ref_clk);
    chk("replay", fwd_replay_r, 1'b1);
    chk("spec_fault", fwd_fault_r, 1'b0);
    ld_issue(6'h1, 32'h40, 2'h2, 1'b0, 1'b1);
    @(negedge ref_clk);
    chk("fault", fwd_fault_r, 1'b1);
    chk("fault_cache", dc_ld_req_r, 1'b0);
    reset();
  endtask : s_fault
  task s_miss();
    alloc(5, 0);
    for (i = 0; i < 3; i++) ld_issue(i, 32'h1000 + 64 * i, 2'h3, 1'b0, 1'b0);
    ld_issue(6'h3, 32'h40, 2'h3, 1'b0, 1'b0);
    await_hi(1);
    chk("hit_first", ld_done_tag_r, 6'h3);
    ld_issue(6'h4, 32'h10c0, 2'h3, 1'b0, 1'b0);
    repeat (2) @(negedge ref_clk);
    chk("miss_full", ld_issue_rdy_r, 1'b0);
    for (i = 0; i < 4; i++) await_hi(1);
    @(negedge ref_clk);
    chk("miss_free", ld_issue_rdy_r, 1'b1);
  endtask : s_miss

  initial begin
    {rst_b, ld_alloc_req, st_alloc_req, ld_issue_valid, ld_issue_spec} = 5'h0;
    {ld_issue_xlat_fault, st_issue_valid, ld_retire, st_retire} = 4'h0;
    {ld_issue_tag, st_issue_tag, ld_issue_size, st_issue_size} = 15'h0;
    {ld_issue_addr, st_issue_addr, st_issue_data} = 128'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk("rst_ld_rdy", ld_alloc_rdy_r, 1'b1);
    chk("rst_issue_rdy", ld_issue_rdy_r, 1'b1);
    s_capacity();
    s_order();
    s_forward();
    s_nofwd(32'h80, 2'h2, 32'h81, 2'h0);
    s_nofwd(32'h80, 2'h2, 32'h80, 2'h3);
    s_nofwd(32'h7c, 2'h3, 32'h7c, 2'h2);
    s_fault();
    s_miss();
    conclude();
  end
endmodule : tb_top
